// ===== mse_far.sv
// Purpose: Remote serial transceiver model on the line side of the extension.
// Assumes: One half bit lasts HALF clocks; the line idles high between frames.
// Notes: The bench calls the tasks; the decoder follows Manchester frames only.
`timescale 1ns/100ps
module mse_far #(
  parameter int HALF = 4
) (
  input wire logic clk_i, // Shared I/O clock.
  input wire logic tx_i, // Line driven by the unit.
  output logic rx_o // Line driven towards the unit.
);
  // ==========================================================
  // Line driver.
  // The line starts idle so the unit never sees a false start bit.
  initial begin
    rx_o = 1'b1;
  end
  // One slot is two halves; Manchester puts the inverse value first.
  task automatic slot(input logic b, input bit man);
    rx_o <= man ? ~b : b;
    repeat (HALF) @(posedge clk_i);
    rx_o <= b;
    repeat (HALF) @(posedge clk_i);
  endtask
  // Start slot, data in the chosen order, then plain stop slots.
  // Stops carry no transition, so a high stop looks like idle line.
  task automatic send(input logic [16:0] w, input int n, input bit man, input bit msb,
    input logic [1:0] st, input int ns);
    @(posedge clk_i);
    slot(1'b0, man);
    for (int i = 0; i < n; i++) begin
      slot(msb ? w[n-1-i] : w[i], man);
    end
    for (int i = 0; i < ns; i++) begin
      slot(st[i], 1'b0);
    end
    rx_o <= 1'b1;
    repeat (2 * HALF) @(posedge clk_i);
  endtask
  // ==========================================================
  // Line decoder.
  // Syncs on the fall in the start slot, then samples each second half.
  task automatic recv(input int n, output logic [16:0] r, output bit ok);
    int k;
    r = '0;
    k = 0;
    while (tx_i !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    ok = (k < 4000);
    repeat (2 * HALF + HALF / 2 - 1) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      r[i] = tx_i;
      repeat (2 * HALF) @(posedge clk_i);
    end
  endtask
endmodule

// ===== mse_pkg.sv
// Purpose: Constants, register map and types of the Manchester serial extension.
// Assumes: AHB-Lite register access, 50 MHz I/O clock.
// Notes: all offsets are byte addresses of aligned words.
package mse_pkg;
  // ==========================================================
  // Register map.
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_RLO = 8'h08;
  localparam logic [7:0] A_RHI = 8'h0c;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_DLO = 8'h14;
  localparam logic [7:0] A_DHI = 8'h18;
  localparam logic [7:0] A_SWST = 8'h1c;
  // ==========================================================
  // Field positions and reset values.
  localparam int CB_EXT = 4;
  localparam int CB_RSTOP = 3;
  localparam int CB_MAN = 1;
  localparam int CB_ORDER = 0;
  localparam int SC_FEM = 3;
  localparam int SC_LONG = 2;
  localparam int CF_TXSZ = 4;
  localparam int CF_SYNC = 8;
  localparam int CF_TSTOP = 9;
  localparam int CF_PAR = 10;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [11:0] CFG_RST = 12'h033;
  localparam logic [15:0] RATE_RST = 16'h0000;
  localparam logic [3:0] SZ_1617 = 4'he;
  localparam logic [4:0] NB_MAX = 5'h11;
  localparam logic [4:0] NB_SHORT = 5'h10;
  typedef enum logic {R_IDLE, R_BUSY} mse_rx_t;
  typedef enum logic {T_IDLE, T_BUSY} mse_tx_t;
  // Character size code to data bit count; reserved codes fall back to 8.
  function automatic logic [4:0] mse_size(input logic [3:0] c);
    case (c)
      4'h0: mse_size = 5'h05;
      4'h1: mse_size = 5'h06;
      4'h2: mse_size = 5'h07;
      4'h7: mse_size = 5'h09;
      4'h8: mse_size = 5'h0d;
      4'h9: mse_size = 5'h0e;
      4'ha: mse_size = 5'h0f;
      4'hb: mse_size = 5'h10;
      4'he: mse_size = 5'h11;
      4'hf: mse_size = 5'h11;
      default: mse_size = 5'h08;
    endcase
  endfunction
endpackage

// ===== mse_top.sv
// Purpose: Extended serial unit with Manchester coding, AHB-Lite registers.
// Assumes: Pins synchronous to clk_i; master never issues back-to-back transfers.
// Notes: Sync mode reuses the rate counter; no separate transfer clock exists.
`timescale 1ns/100ps
module mse_top import mse_pkg::*; (
  input wire logic clk_i, // I/O clock, 50 MHz.
  input wire logic rst_i, // Asynchronous reset, active high.
  input wire logic hsel_i, // Slave select.
  input wire logic [31:0] haddr_i, // Byte address.
  input wire logic [1:0] htrans_i, // Transfer type.
  input wire logic hwrite_i, // Write when high.
  input wire logic [2:0] hsize_i, // Transfer size, word only.
  input wire logic [31:0] hwdata_i, // Write data.
  input wire logic hready_i, // Bus ready.
  output logic [31:0] hrdata_o, // Read data.
  output logic hreadyout_o, // Slave ready.
  output logic hresp_o, // Response, always OKAY.
  input wire logic rx_i, // Serial line in.
  output logic tx_o // Serial line out.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Register state.
  logic [7:0] ctrl_q, ctrl_d;
  logic [11:0] cfg_q, cfg_d;
  logic [15:0] rate_q, rate_d;
  logic [8:0] thi_q, thi_d;
  logic [16:0] rdat_q, rdat_d;
  logic full_q, full_d, ovr_q, ovr_d, fem_q, fem_d, long_q, long_d;
  logic [1:0] stst_q, stst_d;
  logic [31:0] rd_q, rd_d;
  logic wr_q, wr_d;
  logic [7:0] wa_q, wa_d;
  logic acc, rd_low, tx_go, rx_done, rx_err, rx_long, tx_busy;
  logic [16:0] rx_word;
  logic [1:0] rx_stops;
  logic ext, man, msb;

  // Effective mode; the reserved sync plus Manchester pairing falls back to level.
  assign ext = ctrl_q[CB_EXT];
  assign man = ext & ctrl_q[CB_MAN] & ~cfg_q[CF_SYNC];
  assign msb = ext & ctrl_q[CB_ORDER];
  assign acc = hsel_i & hready_i & htrans_i[1];
  assign rd_low = acc & ~hwrite_i & (haddr_i[7:0] == A_DLO);
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = rd_q;

  // ==========================================================
  // Bus slave and flags. Read data is fetched in the address phase, so a read
  // placed right behind a write to the same register would see the old value.
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    rate_d = rate_q;
    thi_d = thi_q;
    rdat_d = rdat_q;
    full_d = full_q;
    ovr_d = ovr_q;
    fem_d = fem_q;
    long_d = long_q;
    stst_d = stst_q;
    rd_d = rd_q;
    wr_d = acc & hwrite_i;
    wa_d = acc ? haddr_i[7:0] : wa_q;
    if (wr_q) begin
      unique case (wa_q)
        A_CTRL: ctrl_d = hwdata_i[7:0] & 8'h1b;
        A_RLO: rate_d[7:0] = hwdata_i[7:0];
        A_RHI: rate_d[15:8] = hwdata_i[7:0];
        A_CFG: cfg_d = hwdata_i[11:0];
        A_DHI: thi_d = hwdata_i[8:0];
        default: ;
      endcase
    end
    if (acc & ~hwrite_i) begin
      unique case (haddr_i[7:0])
        A_CTRL: rd_d = {24'h000000, ctrl_q};
        A_STAT: rd_d = {28'h0000000, fem_q, long_q, stst_q};
        A_RLO: rd_d = {24'h000000, rate_q[7:0]};
        A_RHI: rd_d = {24'h000000, rate_q[15:8]};
        A_CFG: rd_d = {20'h00000, cfg_q};
        A_DLO: rd_d = {24'h000000, rdat_q[7:0]};
        A_DHI: rd_d = {23'h000000, rdat_q[16:8]};
        A_SWST: rd_d = {29'h00000000, tx_busy, ovr_q, full_q};
        default: rd_d = 32'h00000000;
      endcase
    end
    // Reading the low buffer ends the validity of the frame flags.
    if (rd_low) begin
      full_d = 1'b0;
      ovr_d = 1'b0;
      fem_d = 1'b0;
      long_d = 1'b0;
    end
    // A frame landing in the clearing cycle wins over the clear.
    if (rx_done) begin
      full_d = 1'b1;
      ovr_d = full_q & ~rd_low;
      if (full_q & ~rd_low) begin
        ovr_d = 1'b1;
      end else begin
        rdat_d = rx_word;
        fem_d = man & rx_err;
        long_d = (cfg_q[3:0] == SZ_1617) & rx_long;
      end
      if (man) begin
        stst_d = rx_stops;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      cfg_q <= CFG_RST;
      rate_q <= RATE_RST;
      thi_q <= 9'h000;
      rdat_q <= 17'h00000;
      full_q <= 1'b0;
      ovr_q <= 1'b0;
      fem_q <= 1'b0;
      long_q <= 1'b0;
      stst_q <= 2'h0;
      rd_q <= 32'h00000000;
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      rate_q <= rate_d;
      thi_q <= thi_d;
      rdat_q <= rdat_d;
      full_q <= full_d;
      ovr_q <= ovr_d;
      fem_q <= fem_d;
      long_q <= long_d;
      stst_q <= stst_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wa_q <= wa_d;
    end
  end

  AST_OVERRUN: assert property (rx_done && full_q && !rd_low |=> ovr_q && full_q)
    else $error("overrun not flagged");
  AST_READ_CLEARS: assert property (rd_low && !rx_done |=> !fem_q && !long_q && !full_q)
    else $error("low buffer read left flags set");
  AST_LEVEL_KEEPS_STOPS: assert property (rx_done && !man |=> $stable(stst_q))
    else $error("stop status changed in level mode");
  AST_EXT_OFF_LEVEL: assert property (!ext |-> !man && !msb)
    else $error("extended feature active with extension off");
  AST_RESERVED_MODE: assert property (cfg_q[CF_SYNC] |-> !man)
    else $error("Manchester active in sync mode");

  // ==========================================================
  // Receiver: counts half bits, samples each half at its middle.
  mse_rx_t rs_q, rs_d;
  logic [15:0] rcnt_q, rcnt_d;
  logic rph_q, rph_d, rfst_q, rfst_d, rerr_q, rerr_d;
  logic [4:0] rbit_q, rbit_d, rn_q, rn_d;
  logic [1:0] rns_q, rns_d, rstp_q, rstp_d;
  logic [16:0] rsh_q, rsh_d;
  logic rlen_q, rlen_d, rtick, rsamp, viol, short, isstop;
  logic [4:0] sidx, rn_eff;

  assign rtick = (rcnt_q == rate_q);
  assign rsamp = (rcnt_q == {1'b0, rate_q[15:1]});
  assign viol = man & (rfst_q == rx_i);
  assign short = (cfg_q[3:0] == SZ_1617) & man & (rbit_q == NB_MAX) & viol & rx_i;
  assign isstop = (rbit_q > rn_q) | short;
  assign sidx = short ? 5'h00 : 5'(rbit_q - rn_q - 5'h01);
  assign rx_stops = rstp_d;
  // With one stop, a short frame ends in the slot that finds it short, so its length is used at once.
  assign rn_eff = short ? NB_SHORT : rn_q;
  assign rx_long = rlen_d;
  assign rx_err = rerr_d;
  assign rx_word = msb ? (rsh_q & 17'((18'h00001 << rn_eff) - 18'h00001))
                       : 17'(rsh_q >> (NB_MAX - rn_eff));

  always_comb begin
    rs_d = rs_q;
    rcnt_d = rcnt_q;
    rph_d = rph_q;
    rfst_d = rfst_q;
    rerr_d = rerr_q;
    rbit_d = rbit_q;
    rn_d = rn_q;
    rns_d = rns_q;
    rstp_d = rstp_q;
    rsh_d = rsh_q;
    rlen_d = rlen_q;
    rx_done = 1'b0;
    unique case (rs_q)
      R_IDLE: begin
        if (!rx_i) begin
          rs_d = R_BUSY;
          rcnt_d = 16'h0000;
          // A Manchester start slot falls mid-slot, after its high first half.
          rph_d = man;
          rfst_d = 1'b1;
          rbit_d = 5'h00;
          rerr_d = 1'b0;
          rlen_d = 1'b1;
          rn_d = mse_size(cfg_q[3:0]);
          rns_d = (ext ? ctrl_q[CB_RSTOP] : cfg_q[CF_TSTOP]) ? 2'h2 : 2'h1;
        end
      end
      R_BUSY: begin
        // A rate change here is taken at once and spoils this frame.
        rcnt_d = rtick ? 16'h0000 : 16'(rcnt_q + 16'h0001);
        if (rtick) begin
          rph_d = ~rph_q;
        end
        if (rsamp && !rph_q) begin
          rfst_d = rx_i;
        end
        if (rsamp && rph_q) begin
          rbit_d = 5'(rbit_q + 5'h01);
          if (rbit_q == 5'h00) begin
            if (rx_i || viol) begin
              rs_d = R_IDLE;
            end
          end else if (!isstop) begin
            rsh_d = msb ? {rsh_q[15:0], rx_i} : {rx_i, rsh_q[16:1]};
            rerr_d = rerr_q | viol;
          end else begin
            if (short) begin
              rn_d = NB_SHORT;
              rlen_d = 1'b0;
            end
            rstp_d[sidx[0]] = rx_i;
            // Stop slots carry no transition; only a low stop is a framing error.
            rerr_d = rerr_q | ~rx_i;
            if (sidx == 5'(rns_q - 2'h1)) begin
              rx_done = 1'b1;
              rs_d = R_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rs_q <= R_IDLE;
      rcnt_q <= 16'h0000;
      rph_q <= 1'b0;
      rfst_q <= 1'b0;
      rerr_q <= 1'b0;
      rbit_q <= 5'h00;
      rn_q <= 5'h08;
      rns_q <= 2'h1;
      rstp_q <= 2'h0;
      rsh_q <= 17'h00000;
      rlen_q <= 1'b1;
    end else begin
      rs_q <= rs_d;
      rcnt_q <= rcnt_d;
      rph_q <= rph_d;
      rfst_q <= rfst_d;
      rerr_q <= rerr_d;
      rbit_q <= rbit_d;
      rn_q <= rn_d;
      rns_q <= rns_d;
      rstp_q <= rstp_d;
      rsh_q <= rsh_d;
      rlen_q <= rlen_d;
    end
  end

  AST_HALF_BIT_WRAP: assert property (rs_q == R_BUSY && rtick |=> rcnt_q == 16'h0000)
    else $error("receive counter did not wrap at rate");
  AST_RX_STOPS: assert property (rs_q == R_IDLE && !rx_i && ext
                                 |=> rns_q == (ctrl_q[CB_RSTOP] ? 2'h2 : 2'h1))
    else $error("receive stop count wrong");
  AST_FEM_SET: assert property (rx_done && man && rx_err && !full_q |=> fem_q)
    else $error("Manchester framing error not flagged");
  COV_RX_FRAME: cover property (rx_done && man);
  COV_SHORT: cover property (short);
  COV_OVERRUN: cover property (rx_done && full_q);

  // ==========================================================
  // Transmitter: frames start on a low-buffer write while idle; writes
  // to the low buffer during a frame are dropped, software polls the busy bit first.
  mse_tx_t ts_q, ts_d;
  logic [15:0] tcnt_q, tcnt_d;
  logic tph_q, tph_d, tx_q, tx_d, tbit_v, ttick;
  logic [4:0] tbit_q, tbit_d, tn_q, tn_d;
  logic [1:0] tns_q, tns_d;
  logic [16:0] tsh_q, tsh_d, tdat;
  assign tx_busy = (ts_q == T_BUSY);
  assign tx_go = wr_q & (wa_q == A_DLO) & ~tx_busy;
  assign tdat = {thi_q, hwdata_i[7:0]};
  assign ttick = (tcnt_q == rate_q);
  assign tx_o = tx_q;

  always_comb begin
    ts_d = ts_q;
    tcnt_d = tcnt_q;
    tph_d = tph_q;
    tbit_d = tbit_q;
    tn_d = tn_q;
    tns_d = tns_q;
    tsh_d = tsh_q;
    tbit_v = 1'b1;
    tx_d = 1'b1;
    unique case (ts_q)
      T_IDLE: begin
        if (tx_go) begin
          ts_d = T_BUSY;
          tcnt_d = 16'h0000;
          tph_d = 1'b0;
          tbit_d = 5'h00;
          tn_d = mse_size(cfg_q[7:CF_TXSZ]);
          tns_d = cfg_q[CF_TSTOP] ? 2'h2 : 2'h1;
          tsh_d = msb ? 17'(tdat << (NB_MAX - tn_d)) : tdat;
        end
      end
      T_BUSY: begin
        if (tbit_q == 5'h00) begin
          tbit_v = 1'b0;
        end else if (tbit_q <= tn_q) begin
          tbit_v = msb ? tsh_q[16] : tsh_q[0];
        end
        tx_d = (man & ~tph_q & (tbit_q <= tn_q)) ? ~tbit_v : tbit_v;
        tcnt_d = ttick ? 16'h0000 : 16'(tcnt_q + 16'h0001);
        if (ttick) begin
          tph_d = ~tph_q;
          if (tph_q) begin
            tbit_d = 5'(tbit_q + 5'h01);
            if (tbit_q != 5'h00) begin
              tsh_d = msb ? {tsh_q[15:0], 1'b0} : {1'b0, tsh_q[16:1]};
            end
            if (tbit_q == 5'(tn_q + 5'(tns_q))) begin
              ts_d = T_IDLE;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ts_q <= T_IDLE;
      tcnt_q <= 16'h0000;
      tph_q <= 1'b0;
      tbit_q <= 5'h00;
      tn_q <= 5'h08;
      tns_q <= 2'h1;
      tsh_q <= 17'h00000;
      tx_q <= 1'b1;
    end else begin
      ts_q <= ts_d;
      tcnt_q <= tcnt_d;
      tph_q <= tph_d;
      tbit_q <= tbit_d;
      tn_q <= tn_d;
      tns_q <= tns_d;
      tsh_q <= tsh_d;
      tx_q <= tx_d;
    end
  end

  AST_TX_STOPS: assert property (tx_go |=> tns_q == (cfg_q[CF_TSTOP] ? 2'h2 : 2'h1))
    else $error("transmit stop count wrong");
  AST_TX_START_MAN: assert property (tx_go && man |=> ##1 tx_q && !$past(tx_q, 1) == 1'b0)
    else $error("Manchester start half wrong");
  AST_TX_IDLE: assert property (ts_q == T_IDLE && $past(ts_q == T_IDLE) |-> tx_q)
    else $error("line not idle high");
  COV_TX_FRAME: cover property (tx_busy ##1 !tx_busy);
endmodule

// ===== tb_manchester_serial_extension.sv
// Purpose: Self-checking bench of the Manchester serial extension.
// Assumes: A rate value of HALF-1 gives HALF clocks per half bit.
// Notes: Register rows go through one loop; line scenarios follow by hand.
`timescale 1ns/100ps
module tb_manchester_serial_extension;
  import mse_pkg::*;
  localparam int HALF = 4;
  typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} mse_row_t;
  logic clk_i;
  logic rst_i;
  logic hwrite_i;
  logic rx;
  logic tx;
  logic hready;
  logic hresp;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i;
  logic [31:0] hwdata_i;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [16:0] r;
  logic [16:0] w;
  logic [15:0] txw = 16'ha53c;
  bit ok;
  int n_fail = 0;
  int tests_run = 0;
  // ==========================================================
  // Register rows: reset values first, then write and read back.
  // Reserved control bits are never written, so only defined fields move.
  mse_row_t rows [10] = '{
    '{1'b0, A_CTRL, 32'h0, {24'h0, CTRL_RST}}, '{1'b0, A_STAT, 32'h0, 32'h0},
    '{1'b0, A_RLO, 32'h0, {24'h0, RATE_RST[7:0]}}, '{1'b0, A_RHI, 32'h0, 32'h0},
    '{1'b0, A_CFG, 32'h0, {20'h0, CFG_RST}}, '{1'b0, 8'h20, 32'h0, 32'h0},
    '{1'b1, A_CTRL, 32'h1b, 32'h1b}, '{1'b1, A_RLO, 32'h1234, 32'h34},
    '{1'b1, A_RHI, 32'hc5, 32'hc5}, '{1'b1, A_STAT, 32'h0f, 32'h0}};
  // ==========================================================
  // Design and line partner; the one slave's ready is the bus ready.
  mse_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rx_i(rx), .tx_o(tx));
  mse_far #(.HALF(HALF)) far_u (.clk_i(clk_i), .tx_i(tx), .rx_o(rx));
  // Free-running 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Compare and count.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Single closing point of the run.
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Bounded wait for ready sampled high at a rising edge.
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (hready !== 1'b1 && k < 50);
    if (hready !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask
  // One single transfer; the idle edge first keeps transfers apart.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= wr;
    wait_rdy();
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wait_rdy();
    rd = hrdata;
  endtask
  // Read one register and compare the masked value.
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  // Hang guard.
  initial begin
    repeat (100000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
  // ==========================================================
  // Main sequence.
  initial begin
    rst_i = 1'b1;
    htrans_i = 2'h0;
    haddr_i = 32'h0;
    hwrite_i = 1'b0;
    hwdata_i = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        xfer(1'b1, rows[i].a, rows[i].d);
      end
      rchk(rows[i].a, 32'hffffffff, rows[i].e);
    end
    // Rate is changed only while the receiver is idle.
    xfer(1'b1, A_RLO, 32'(HALF - 1));
    xfer(1'b1, A_RHI, 32'h0);
    xfer(1'b1, A_CFG, {24'h0, 4'hb, SZ_1617});
    xfer(1'b1, A_CTRL, 32'h12);
    // Seventeen-bit Manchester frame, LSB first.
    far_u.send(17'h1a5c3, 17, 1'b1, 1'b0, 2'h1, 1);
    rchk(A_SWST, 32'h1, 32'h1);
    rchk(A_STAT, 32'hc, 32'h4);
    rchk(A_DHI, 32'h1ff, 32'h1a5);
    rchk(A_DLO, 32'hff, 32'hc3);
    rchk(A_STAT, 32'hc, 32'h0);
    // Sixteen-bit frame sent MSB first.
    xfer(1'b1, A_CTRL, 32'h13);
    far_u.send(17'h05a3c, 16, 1'b1, 1'b1, 2'h1, 1);
    rchk(A_STAT, 32'hc, 32'h0);
    rchk(A_DHI, 32'h1ff, 32'h05a);
    rchk(A_DLO, 32'hff, 32'h3c);
    // Two stops expected, both sent low.
    xfer(1'b1, A_CFG, {24'h0, 4'hb, 4'hb});
    xfer(1'b1, A_CTRL, 32'h1a);
    far_u.send(17'h0f0f0, 16, 1'b1, 1'b0, 2'h0, 2);
    rchk(A_STAT, 32'hb, 32'h8);
    xfer(1'b0, A_DLO, 32'h0);
    // Level frame must leave the captured stop field alone.
    xfer(1'b1, A_CTRL, 32'h18);
    far_u.send(17'h01234, 16, 1'b0, 1'b0, 2'h3, 2);
    rchk(A_STAT, 32'hb, 32'h0);
    rchk(A_DHI, 32'h1ff, 32'h012);
    rchk(A_DLO, 32'hff, 32'h34);
    // Manchester transmit, MSB first, decoded by the partner.
    xfer(1'b1, A_CTRL, 32'h13);
    fork
      far_u.recv(16, r, ok);
      begin
        xfer(1'b1, A_DHI, {24'h0, txw[15:8]});
        xfer(1'b1, A_DLO, {24'h0, txw[7:0]});
      end
    join
    w = '0;
    for (int i = 0; i < 16; i++) begin
      w[i] = txw[15-i];
    end
    chk({31'h0, ok}, 32'h1);
    chk({31'h0, hresp}, 32'h0);
    chk({15'h0, r}, {15'h0, w});
    finish_test();
  end
endmodule
